// file: logic/bldcp_pkg.sv
// Shared constants and types of the brushless commutation and protection block
package bldcp_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_LEVELS = 8'h00;
  localparam logic [7:0] ADDR_LOCK_CAP = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // ------------------------------------------------------------
  // Level register fields and reset values (8-bit command codes), then the 16-bit lock capacitor reset
  // ------------------------------------------------------------
  localparam int LVL_ALL_OFF_POS = 0;
  localparam int LVL_SAW_LOW_POS = 8;
  localparam int LVL_SAW_HIGH_POS = 16;
  localparam int LVL_LOCK_INH_POS = 24;
  localparam logic [7:0] ALL_OFF_RST = 8'h31;
  localparam logic [7:0] SAW_LOW_RST = 8'h54;
  localparam logic [7:0] SAW_HIGH_RST = 8'hD8;
  localparam logic [7:0] LOCK_INH_RST = 8'h58;
  localparam logic [15:0] LOCK_CAP_RST = 16'h03E8;

  // ------------------------------------------------------------
  // Event bits of the interrupt status and mask registers
  // ------------------------------------------------------------
  localparam int EV_LIMIT = 0;
  localparam int EV_OVERCURRENT = 1;
  localparam int EV_UNDERVOLT = 2;
  localparam int EV_THERMAL = 3;
  localparam int EV_LOCK = 4;
  localparam int EV_W = 5;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int OC_RECOVERY_US = 1000;
  localparam int OC_RECOVERY_CYC = OC_RECOVERY_US * CLK_MHZ;
  localparam int LOCK_REF_PF = 1000;
  localparam int LOCK_DETECT_US = 2000;
  localparam int LOCK_RETRY_US = 12000;
  localparam int SAW_DIV_RST = 47;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic top;
    logic bot;
  } bldcp_leg_t;

  typedef struct packed {
    bldcp_leg_t a;
    bldcp_leg_t b;
    bldcp_leg_t c;
  } bldcp_arms_t;

  typedef enum logic {LOCK_WATCH, LOCK_HELD} bldcp_lock_t;

endpackage

// file: logic/bldcp_core.sv
// Commutation, PWM and protection logic of a three-phase motor driver
// Operation
// - Hall code picks one top and one bottom arm; 000 and 111 turn all off.
// - Single tach follows phase A Hall; triple tach high when two or more high.
// - PWM is speed command above sawtooth, applied to bottom arms only.
// - Current limit trip forces bottoms off until next sawtooth period.
// - Over-current trip forces all off for the recovery time.
// - Undervoltage holds all off until supply passes the higher release level.
// - Command between all-off and sawtooth low keeps bottoms off, tops decoded.
// - Command below all-off level turns every arm off.
// - Triple tach constant for detect time locks all off for retry time.
// - Both lock times scale linearly with the lock capacitor value.
// - Lock detection is suppressed at low command, undervoltage or overheat.
// - Overheat trips all off; release only below the lower temperature.
// - Hall bias is on while the command is at or above all-off level.
// - With bias off Hall inputs read low, so both tachs go low.
// - Lock timer runs regardless of the high-voltage rail.
`timescale 1ns/1ps
`default_nettype none
module bldcp_core
  import bldcp_pkg::*;
#(
  parameter int OC_RECOVERY_CYCLES = OC_RECOVERY_CYC,
  parameter int LOCK_DETECT_TICKS = LOCK_DETECT_US,
  parameter int LOCK_RETRY_TICKS = LOCK_RETRY_US,
  parameter int SAW_DIV = SAW_DIV_RST
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Hall sensors and analog comparator flags
  input wire logic hall_phase_a,
  input wire logic hall_phase_b,
  input wire logic hall_phase_c,
  input wire logic limit_trip_in,
  input wire logic overcurrent_trip_in,
  input wire logic uv_below_trip_in,
  input wire logic uv_above_release_in,
  input wire logic temp_above_trip_in,
  input wire logic temp_below_release_in,
  // Speed command code from the on-chip converter, same clock
  input wire logic [7:0] speed_command_in,
  // Gate commands, tachometers, Hall bias, interrupt
  output bldcp_leg_t phase_a_out,
  output bldcp_leg_t phase_b_out,
  output bldcp_leg_t phase_c_out,
  output logic sensor_bias_out,
  output logic triple_rate_tach,
  output logic single_rate_tach,
  output logic irq
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [8:0] pins_raw, syn1_q, syn2_q;
  assign pins_raw = {hall_phase_a, hall_phase_b, hall_phase_c,
                     limit_trip_in, overcurrent_trip_in, uv_below_trip_in,
                     uv_above_release_in, temp_above_trip_in,
                     temp_below_release_in};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      syn1_q <= 9'h000;
      syn2_q <= 9'h000;
    end else begin
      syn1_q <= pins_raw;
      syn2_q <= syn1_q;
    end
  end
  logic [2:0] hall_s;
  logic lim_s, oc_s, uv_trip_s, uv_rel_s, ot_trip_s, ot_rel_s;
  assign {hall_s, lim_s, oc_s, uv_trip_s, uv_rel_s, ot_trip_s,
          ot_rel_s} = syn2_q;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [31:0] levels_q, levels_d, prdata_q, prdata_d;
  logic [15:0] cap_q, cap_d, sdiv_q, sdiv_d, lock_cnt_q, lock_cnt_d;
  logic [EV_W-1:0] mask_q, mask_d, ist_q, ist_d;
  logic [7:0] saw_q, saw_d;
  logic [23:0] oc_cnt_q, oc_cnt_d, lock_acc_q, lock_acc_d;
  logic ilim_q, ilim_d, oc_q, oc_d, uv_q, uv_d, ot_q, ot_d;
  bldcp_lock_t lock_q, lock_d;
  logic tach_prev_q, tach_prev_d, bias_q, bias_d, tach3_q, tach3_d;
  bldcp_arms_t arms_q, arms_d;
  logic tach1_q, tach1_d, irq_q, irq_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [7:0] all_off_lvl, saw_low, saw_high, lock_inh;
  assign all_off_lvl = levels_q[LVL_ALL_OFF_POS +: 8];
  assign saw_low = levels_q[LVL_SAW_LOW_POS +: 8];
  assign saw_high = levels_q[LVL_SAW_HIGH_POS +: 8];
  assign lock_inh = levels_q[LVL_LOCK_INH_POS +: 8];
  // Shared combinational terms
  logic [2:0] hall_eff;
  logic saw_wrap, pwm, below_off, stop_band, lock_inhibit, lock_tick;
  logic shutdown, apb_done, addr_ok;
  logic [EV_W-1:0] ev;
  logic [23:0] lock_thr;
  bldcp_arms_t dec;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    // Hall inputs read low while the sensor bias is off
    hall_eff = bias_q ? hall_s : 3'h0;
    below_off = speed_command_in < all_off_lvl;
    stop_band = !below_off && (speed_command_in < saw_low);
    bias_d = !below_off;
    // Sawtooth: one step per SAW_DIV cycles, low to high, then wrap
    saw_wrap = 1'b0;
    sdiv_d = sdiv_q + 16'h0001;
    saw_d = saw_q;
    if (sdiv_q >= 16'(SAW_DIV - 1)) begin
      sdiv_d = 16'h0000;
      if (saw_q >= saw_high) begin
        saw_d = saw_low;
        saw_wrap = 1'b1;
      end else begin
        saw_d = saw_q + 8'h01;
      end
    end
    pwm = speed_command_in > saw_q;
    // Cycle-by-cycle limit; a new trip wins over the period reset
    ilim_d = ilim_q;
    if (saw_wrap) begin
      ilim_d = 1'b0;
    end
    if (lim_s) begin
      ilim_d = 1'b1;
    end

    // Over-current shutdown with timed recovery
    oc_d = oc_q;
    oc_cnt_d = oc_cnt_q;
    if (oc_q) begin
      if (oc_cnt_q >= 24'(OC_RECOVERY_CYCLES - 1)) begin
        oc_d = 1'b0;
        oc_cnt_d = 24'h000000;
      end else begin
        oc_cnt_d = oc_cnt_q + 24'h000001;
      end
    end else if (oc_s) begin
      oc_d = 1'b1;
      oc_cnt_d = 24'h000000;
    end

    // Hysteresis latches for supply and temperature
    uv_d = uv_q;
    if (uv_trip_s) begin
      uv_d = 1'b1;
    end else if (uv_rel_s) begin
      uv_d = 1'b0;
    end
    ot_d = ot_q;
    if (ot_trip_s) begin
      ot_d = 1'b1;
    end else if (ot_rel_s) begin
      ot_d = 1'b0;
    end
    // Lock time base: tick period is cap_pf/1000 microseconds, so both
    // lock times follow the capacitor; a zero value is a grounded node.
    // Widen before the product, the reset value overflows 16 bits
    lock_thr = 24'(cap_q) * 24'(CLK_MHZ);
    lock_acc_d = lock_acc_q + 24'(LOCK_REF_PF);
    lock_tick = 1'b0;
    if (cap_q == 16'h0000) begin
      lock_acc_d = 24'h000000;
    end else if (lock_acc_d >= lock_thr) begin
      lock_acc_d = lock_acc_d - lock_thr;
      lock_tick = 1'b1;
    end
    // No high-voltage rail term enters here, so a late rail can trip it
    lock_inhibit = (speed_command_in <= lock_inh) || uv_q || ot_q
                   || (cap_q == 16'h0000);
    tach_prev_d = tach3_q;
    lock_d = lock_q;
    lock_cnt_d = lock_cnt_q;
    case (lock_q)
      LOCK_WATCH: begin
        if (lock_inhibit || (tach3_q != tach_prev_q)) begin
          lock_cnt_d = 16'h0000;
        end else if (lock_tick) begin
          if (lock_cnt_q >= 16'(LOCK_DETECT_TICKS - 1)) begin
            lock_d = LOCK_HELD;
            lock_cnt_d = 16'h0000;
          end else begin
            lock_cnt_d = lock_cnt_q + 16'h0001;
          end
        end
      end
      LOCK_HELD: begin
        if (lock_tick) begin
          if (lock_cnt_q >= 16'(LOCK_RETRY_TICKS - 1)) begin
            lock_d = LOCK_WATCH;
            lock_cnt_d = 16'h0000;
          end else begin
            lock_cnt_d = lock_cnt_q + 16'h0001;
          end
        end
      end
      default: begin
        lock_d = LOCK_WATCH;
        lock_cnt_d = 16'h0000;
      end
    endcase

    // Hall decode; codes 1 to 6 each enable one top and one other-phase bottom
    dec = '0;
    case (hall_eff)
      3'h5: begin
        dec.b.top = 1'b1;
        dec.a.bot = 1'b1;
      end
      3'h4: begin
        dec.c.top = 1'b1;
        dec.a.bot = 1'b1;
      end
      3'h6: begin
        dec.c.top = 1'b1;
        dec.b.bot = 1'b1;
      end
      3'h2: begin
        dec.a.top = 1'b1;
        dec.b.bot = 1'b1;
      end
      3'h3: begin
        dec.a.top = 1'b1;
        dec.c.bot = 1'b1;
      end
      3'h1: begin
        dec.b.top = 1'b1;
        dec.c.bot = 1'b1;
      end
      default: dec = '0;
    endcase

    // Bottoms carry the PWM, gated by limit and the stop band
    if (!pwm || ilim_q || lim_s || stop_band) begin
      dec.a.bot = 1'b0;
      dec.b.bot = 1'b0;
      dec.c.bot = 1'b0;
    end
    shutdown = oc_q || uv_q || ot_q || (lock_q == LOCK_HELD) || below_off;
    arms_d = shutdown ? '0 : dec;

    tach1_d = hall_eff[2];
    tach3_d = (hall_eff[2] & hall_eff[1]) | (hall_eff[2] & hall_eff[0])
              | (hall_eff[1] & hall_eff[0]);

    // Events and interrupt status; a new event wins over read-clear
    ev = '0;
    ev[EV_LIMIT] = ilim_d & !ilim_q;
    ev[EV_OVERCURRENT] = oc_d & !oc_q;
    ev[EV_UNDERVOLT] = uv_d & !uv_q;
    ev[EV_THERMAL] = ot_d & !ot_q;
    ev[EV_LOCK] = (lock_d == LOCK_HELD) && (lock_q == LOCK_WATCH);

    // APB: one wait state, answer registered
    apb_done = psel && penable && pready_q;
    addr_ok = (paddr == ADDR_LEVELS) || (paddr == ADDR_LOCK_CAP)
              || (paddr == ADDR_STATE) || (paddr == ADDR_IRQ_STAT)
              || (paddr == ADDR_IRQ_MASK);
    pready_d = psel && penable && !pready_q;
    pslverr_d = pready_d && !addr_ok;
    prdata_d = prdata_q;
    if (pready_d) begin
      case (paddr)
        ADDR_LEVELS: prdata_d = levels_q;
        ADDR_LOCK_CAP: prdata_d = {16'h0000, cap_q};
        ADDR_STATE: prdata_d = {24'h000000, bias_q, lock_q == LOCK_HELD,
                                ot_q, uv_q, oc_q, ilim_q, tach3_q,
                                tach1_q};
        ADDR_IRQ_STAT: prdata_d = {27'h0000000, ist_q};
        ADDR_IRQ_MASK: prdata_d = {27'h0000000, mask_q};
        default: prdata_d = 32'h00000000;
      endcase
    end

    levels_d = levels_q;
    cap_d = cap_q;
    mask_d = mask_q;
    ist_d = ist_q;
    if (apb_done && pwrite) begin
      case (paddr)
        ADDR_LEVELS: levels_d = pwdata;
        ADDR_LOCK_CAP: cap_d = pwdata[15:0];
        ADDR_IRQ_MASK: mask_d = pwdata[EV_W-1:0];
        default: levels_d = levels_q;
      endcase
    end
    if (apb_done && !pwrite && (paddr == ADDR_IRQ_STAT)) begin
      ist_d = '0;
    end
    ist_d = ist_d | ev;
    irq_d = |(ist_d & mask_d);
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      levels_q <= {LOCK_INH_RST, SAW_HIGH_RST, SAW_LOW_RST, ALL_OFF_RST};
      cap_q <= LOCK_CAP_RST;
      mask_q <= '0;
      ist_q <= '0;
      sdiv_q <= 16'h0000;
      saw_q <= SAW_LOW_RST;
      oc_cnt_q <= 24'h000000;
      uv_q <= 1'b1;
      lock_q <= LOCK_WATCH;
      lock_cnt_q <= 16'h0000;
      lock_acc_q <= 24'h000000;
      arms_q <= '0;
      prdata_q <= 32'h00000000;
      {ilim_q, oc_q, ot_q, tach_prev_q, bias_q, tach3_q, tach1_q, irq_q,
       pready_q, pslverr_q} <= '0;
    end else begin
      levels_q <= levels_d;
      cap_q <= cap_d;
      mask_q <= mask_d;
      ist_q <= ist_d;
      sdiv_q <= sdiv_d;
      saw_q <= saw_d;
      oc_cnt_q <= oc_cnt_d;
      uv_q <= uv_d;
      lock_q <= lock_d;
      lock_cnt_q <= lock_cnt_d;
      lock_acc_q <= lock_acc_d;
      arms_q <= arms_d;
      prdata_q <= prdata_d;
      {ilim_q, oc_q, ot_q, tach_prev_q, bias_q, tach3_q, tach1_q, irq_q,
       pready_q, pslverr_q} <= {ilim_d, oc_d, ot_d, tach_prev_d, bias_d,
       tach3_d, tach1_d, irq_d, pready_d, pslverr_d};
    end
  end
  assign phase_a_out = arms_q.a;
  assign phase_b_out = arms_q.b;
  assign phase_c_out = arms_q.c;
  assign sensor_bias_out = bias_q;
  assign triple_rate_tach = tach3_q;
  assign single_rate_tach = tach1_q;
  assign irq = irq_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic bots_on;
  assign bots_on = arms_q.a.bot | arms_q.b.bot | arms_q.c.bot;
  sequence s_oc_trip;
    !oc_q ##1 oc_q;
  endsequence
  a_no_shoot_through: assert property (
    !(arms_q.a.top & arms_q.a.bot) && !(arms_q.b.top & arms_q.b.bot)
    && !(arms_q.c.top & arms_q.c.bot))
    else $error("Top and bottom of one phase on together");
  a_limit_bottoms: assert property (ilim_q |=> !bots_on)
    else $error("Bottom arm on during current limit");
  a_oc_hold: assert property (
    s_oc_trip |-> oc_q[*8] ##0 arms_q == '0)
    else $error("Over-current shutdown not held");
  a_oc_off: assert property (oc_q |=> arms_q == '0)
    else $error("Arm on during over-current");
  a_uv_off: assert property (uv_q |=> arms_q == '0)
    else $error("Arm on during undervoltage");
  a_ot_off: assert property (ot_q |=> arms_q == '0)
    else $error("Arm on during overheat");
  a_stop_band: assert property (stop_band |=> !bots_on)
    else $error("Bottom arm on in stop band");
  a_all_off_level: assert property (
    below_off |=> (arms_q == '0) && !sensor_bias_out ##1 !tach1_q && !tach3_q)
    else $error("Outputs active below all-off level");
  a_lock_off: assert property (lock_q == LOCK_HELD |=> arms_q == '0)
    else $error("Arm on while motor lock held");
  a_lock_inhibit: assert property (
    lock_inhibit && lock_q == LOCK_WATCH |=> lock_q == LOCK_WATCH)
    else $error("Lock detected while suppressed");
endmodule
`default_nettype wire

// file: verification/bldcp_motor_model.sv
// Behavioural motor with Hall sensors facing the driver
`timescale 1ns/1ps
`default_nettype none
module bldcp_motor_model (
  // Clock
  input wire logic pclk,
  // Hall bias from the driver and rotor position from the bench
  input wire logic sensor_bias_out,
  input wire logic [2:0] rotor_code,
  // Hall levels seen by the driver
  output logic hall_phase_a,
  output logic hall_phase_b,
  output logic hall_phase_c
);
  logic [2:0] pos_q;
  // Rotor position moves only on a clock edge, never mid-cycle
  always_ff @(posedge pclk) begin
    pos_q <= rotor_code;
  end
  // Unpowered Hall elements pull every input low
  assign {hall_phase_a, hall_phase_b, hall_phase_c} =
    sensor_bias_out ? pos_q : 3'h0;
endmodule
`default_nettype wire

// file: verification/bldcp_core_tb.sv
// Self-checking testbench of the commutation and protection block
`timescale 1ns/1ps
`default_nettype none
module bldcp_core_tb;
  import bldcp_pkg::*;
  // ------------------------------------------------------------
  // Signals and expectations
  // ------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pslverr, pready, irq, er;
  logic ha, hb, hc, lim, oc, uvb, uva, tha, thb, bias, t3, t1;
  logic [7:0] paddr, spd;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] rot;
  bldcp_leg_t pa, pb, pc;
  int miscompares = 0;
  int cmp_count = 0;
  int n;
  // Arms per Hall code {a,b,c}, bits {at,ab,bt,bb,ct,cb}
  logic [5:0] tbl [8] = '{6'h00, 6'h09, 6'h24, 6'h21, 6'h12, 6'h18,
    6'h06, 6'h00};
  logic [7:0] tri_m = 8'hE8;
  wire logic [5:0] arms = {pa, pb, pc};
  always #4 pclk = ~pclk;

  bldcp_core #(.OC_RECOVERY_CYCLES(50), .LOCK_DETECT_TICKS(4),
    .LOCK_RETRY_TICKS(6), .SAW_DIV(2)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hall_phase_a(ha),
    .hall_phase_b(hb), .hall_phase_c(hc), .limit_trip_in(lim),
    .overcurrent_trip_in(oc), .uv_below_trip_in(uvb),
    .uv_above_release_in(uva), .temp_above_trip_in(tha),
    .temp_below_release_in(thb), .speed_command_in(spd),
    .phase_a_out(pa), .phase_b_out(pb), .phase_c_out(pc),
    .sensor_bias_out(bias), .triple_rate_tach(t3),
    .single_rate_tach(t1), .irq(irq));
  bldcp_motor_model motor (.pclk(pclk), .sensor_bias_out(bias),
    .rotor_code(rot), .hall_phase_a(ha), .hall_phase_b(hb),
    .hall_phase_c(hc));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Master holds the request until pready is seen at an edge;
  // only the watchdog ends a wait that never sees an answer
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rd);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic wait_arms(input logic [5:0] e, input int lc);
    n = 0;
    while (arms !== e && n < lc) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run is near 1000 cycles; twenty times that means a hang
  initial begin
    cyc(20000);
    miscompares++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, lim, oc, uvb, tha} = 8'h00;
    {uva, thb} = 2'b11;
    paddr = 8'h00;
    pwdata = 32'h0;
    spd = 8'hFF;
    rot = 3'h5;
    cyc(20);
    presetn <= 1'b1;
    cyc(1);
    rdc(ADDR_LEVELS, {LOCK_INH_RST, SAW_HIGH_RST, SAW_LOW_RST, ALL_OFF_RST});
    rdc(ADDR_LOCK_CAP, {16'h0000, LOCK_CAP_RST});
    rdc(ADDR_IRQ_MASK, 32'h0);
    rdc(8'h14, 32'h0);
    chk("pslverr", 1'b1, er);
    // Lock off while the other tests hold the rotor still
    apb(1'b1, ADDR_LOCK_CAP, 32'h0);
    cyc(10);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      rot <= i[2:0];
      cyc(6);
      chk("arms", tbl[i], arms);
      chk("tach3", tri_m[i], t3);
      chk("tach1", i[2], t1);
    end
    rot <= 3'h5;
    spd <= ALL_OFF_RST - 8'h01;
    cyc(6);
    chk("arms", 6'h00, arms);
    chk("bias", 1'b0, bias);
    chk("tachs", 2'b00, {t3, t1});
    spd <= ALL_OFF_RST;
    cyc(6);
    chk("bias", 1'b1, bias);
    chk("arms", 6'h08, arms);
    spd <= 8'h96;
    cyc(6);
    n = 0;
    repeat (266) begin
      @(posedge pclk);
      if (pa.bot === 1'b1) n++;
      if (pb.top !== 1'b1) n += 1000;
    end
    chk("pwm_on", 1'b1, n >= 128 && n <= 136);
    $display("test decode done");
    spd <= 8'hFF;
    cyc(6);
    lim <= 1'b1;
    cyc(1);
    lim <= 1'b0;
    wait_arms(6'h08, 10);
    chk("limit_off", 1'b1, n < 10);
    wait_arms(6'h18, 300);
    chk("limit_clear", 1'b1, n < 300);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1 << EV_OVERCURRENT);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("stat_limit", 1'b1, rd[EV_LIMIT]);
    cyc(3);
    chk("irq", 1'b0, irq);
    oc <= 1'b1;
    cyc(1);
    oc <= 1'b0;
    wait_arms(6'h00, 10);
    chk("oc_off", 1'b1, n < 10);
    wait_arms(6'h18, 80);
    chk("oc_recover", 1'b1, n >= 44 && n <= 56);
    chk("irq", 1'b1, irq);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("stat_oc", 1'b1, rd[EV_OVERCURRENT]);
    cyc(3);
    chk("irq", 1'b0, irq);
    $display("test current done");
    uvb <= 1'b1;
    uva <= 1'b0;
    cyc(6);
    chk("arms", 6'h00, arms);
    // Status word: bias, undervoltage and both tachs high, rotor code 5
    rdc(ADDR_STATE, 32'h00000093);
    uvb <= 1'b0;
    cyc(10);
    chk("arms", 6'h00, arms);
    uva <= 1'b1;
    cyc(6);
    chk("arms", 6'h18, arms);
    tha <= 1'b1;
    thb <= 1'b0;
    cyc(6);
    chk("arms", 6'h00, arms);
    tha <= 1'b0;
    cyc(10);
    chk("arms", 6'h00, arms);
    thb <= 1'b1;
    cyc(6);
    chk("arms", 6'h18, arms);
    $display("test supply done");
    apb(1'b1, ADDR_LOCK_CAP, 32'h8);
    wait_arms(6'h00, 60);
    chk("lock_off", 1'b1, n < 60);
    wait_arms(6'h18, 60);
    chk("lock_retry", 1'b1, n >= 3 && n <= 12);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("stat_lock", 1'b1, rd[EV_LOCK]);
    spd <= 8'h50;
    cyc(20);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    cyc(60);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("stat_lock", 1'b0, rd[EV_LOCK]);
    chk("arms", 6'h08, arms);
    apb(1'b1, ADDR_LOCK_CAP, 32'h0);
    spd <= 8'hFF;
    cyc(20);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    cyc(100);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("stat_lock", 1'b0, rd[EV_LOCK]);
    chk("arms", 6'h18, arms);
    $display("test lock done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
